//--- core/cbbl_pkg.sv
/*
  Shared constants and types for the bit-operation, branch and load
  execution block: register map, instruction word layout, status flag
  positions, reset values and state encodings.
  Assumes a single 25 MHz core clock and a 32-bit classic Wishbone bus.
*/
package cbbl_pkg;

  // Wishbone register map (byte addresses)
  localparam int ADR_W = 8;
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_PC = 8'h04;
  localparam logic [7:0] ADR_FLAGS = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_SEL = 8'h10;
  localparam logic [7:0] ADR_REGDATA = 8'h14;
  localparam logic [7:0] ADR_MEMDATA = 8'h18;
  localparam logic [7:0] ADR_IODATA = 8'h1C;

  // Instruction word fields
  localparam int OP_POS = 24;
  localparam int OP_W = 5;
  localparam int RD_POS = 16;
  localparam int RR_POS = 8;
  localparam int IMM_POS = 0;

  // Status register flag positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_S = 4;
  localparam int SR_H = 5;
  localparam int SR_T = 6;
  localparam int SR_I = 7;

  // Status word field positions
  localparam int ST_BUSY_POS = 0;
  localparam int ST_CYC_POS = 1;
  localparam int ST_TAKEN_POS = 3;

  // Reset values
  localparam logic [31:0] INSTR_RST = 32'h0000_0000;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;

  // Data memory and pointer layout
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam logic [4:0] PTR_X_LO = 5'h1A;

  typedef enum logic [4:0] {
    op_nop = 5'h00, op_br_tclr = 5'h01, op_br_vset = 5'h02,
    op_br_vclr = 5'h03, op_br_ion = 5'h04, op_br_ioff = 5'h05,
    op_io_set = 5'h06, op_io_clr = 5'h07, op_shl = 5'h08,
    op_shr = 5'h09, op_rot_left = 5'h0A, op_rot_right = 5'h0B,
    op_sra = 5'h0C, op_swap = 5'h0D, op_flag_set = 5'h0E,
    op_flag_clr = 5'h0F, op_bit_to_t = 5'h10, op_t_to_bit = 5'h11,
    op_copy = 5'h12, op_copy_pair = 5'h13, op_imm = 5'h14,
    op_load = 5'h15, op_load_inc = 5'h16, op_load_dec = 5'h17,
    op_load_disp = 5'h18
  } cbbl_op_t;

  typedef enum logic [2:0] {
    st_idle = 3'b001, st_first = 3'b010, st_second = 3'b100
  } cbbl_state_t;

  typedef enum logic [2:0] {
    sh_left = 3'h0, sh_right = 3'h1, sh_rot_left = 3'h2,
    sh_rot_right = 3'h3, sh_arith = 3'h4
  } cbbl_shift_t;

  // Relative target: following instruction plus signed word offset
  function automatic logic [15:0] pc_rel(input logic [15:0] pc,
                                         input logic [6:0] k);
    pc_rel = pc + 16'h0001 + {{9{k[6]}}, k};
  endfunction : pc_rel

  // Byte-lane merge of a Wishbone write into an old word
  function automatic logic [31:0] wb_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] lanes);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) m[8*i +: 8] = new_w[8*i +: 8];
    end
    wb_merge = m;
  endfunction : wb_merge

endpackage : cbbl_pkg

//--- core/cbbl_shift_unit.sv
/*
  Combinational shifter for the left, right, rotate and arithmetic
  shifts, with the zero, carry, negative and overflow results.
  Assumes the caller picks the kind and supplies the current carry.
*/
`timescale 1ns/100ps
module cbbl_shift_unit (
  input wire cbbl_pkg::cbbl_shift_t kind,
  input wire logic [7:0] val,
  input wire logic cin,
  output logic [7:0] res,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out
);
  import cbbl_pkg::*;

  // Shift and carry-out per kind
  always_comb begin
    case (kind)
      sh_left: {c_out, res} = {val, 1'b0};
      sh_rot_left: {c_out, res} = {val, cin};
      sh_right: {res, c_out} = {1'b0, val};
      sh_rot_right: {res, c_out} = {cin, val};
      default: {res, c_out} = {val[7], val}; // Sign bit kept
    endcase
  end

  // Flags follow the result; overflow is negative xor carry
  assign z_out = (res == 8'h00);
  assign n_out = res[7];
  assign v_out = n_out ^ c_out;

endmodule : cbbl_shift_unit

//--- core/cbbl_data_mem.sv
/*
  Byte-wide data memory read by the pointer loads.
  Assumes one writer and an asynchronous read port on the same clock.
*/
`timescale 1ns/100ps
module cbbl_data_mem (
  input wire logic mclk,
  input wire logic [cbbl_pkg::MEM_AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic [cbbl_pkg::MEM_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  import cbbl_pkg::*;

  logic [7:0] mem_q [0:MEM_DEPTH-1];

  // Contents are not reset; software loads them before use
  always_ff @(posedge mclk) begin
    if (wr_en) mem_q[wr_addr] <= wr_data;
  end

  assign rd_data = mem_q[rd_addr];

endmodule : cbbl_data_mem

//--- core/cbbl_exec_core.sv
/*
  Execution unit for branches on status flags, I/O bit set and clear,
  shifts, flag operations, bit transfer, register moves and pointer
  loads. Software issues one instruction word at a time over Wishbone.
  Assumes a classic Wishbone master on mclk and no other writer.
*/
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
// What this block does
// - Branch on transfer flag clear to PC+k+1; one or two cycles.
// - Branch on overflow set to PC+k+1; flags kept; one or two cycles.
// - Branch on overflow clear to PC+k+1; flags kept; one or two.
// - Branch on interrupt flag set, or clear; PC+k+1; one or two.
// - I/O bit set or clear; other bits and flags kept; two cycles.
// - Left shift and rotate; carry from bit 7; Z,C,N,V; one cycle.
// - Right shift and rotate; carry from bit 0; Z,C,N,V; one cycle.
// - Arithmetic right shift keeps sign bit; Z,C,N,V; one cycle.
// - Flag set forces only the chosen status flag to one.
// - Flag clear forces only the chosen status flag to zero.
// - Chosen register bit is copied into transfer flag; one cycle.
// - Transfer flag is written into chosen register bit; one cycle.
// - Global interrupt on and off change only that flag.
// - Register, pair and immediate copies leave flags; one cycle.
// - Post-increment load reads at pointer, then pointer plus one.
// - Pre-decrement load lowers pointer, then reads; two cycles.
// - Displacement load reads pointer plus q; pointer kept.
module cbbl_exec_core (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cbbl_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import cbbl_pkg::*;

  logic [7:0] rf_q [0:31];
  logic [7:0] io_q [0:31];
  cbbl_state_t state_q, state_d;
  logic [31:0] instr_q;
  logic [15:0] pc_q, pc_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] sel_q;
  logic ack_q;
  logic [31:0] dat_q, rd_mux;
  logic [1:0] cyc_q, cyc_d;
  logic taken_q, taken_d;
  logic [15:0] addr_q, addr_d;
  logic wa_en, pr_en, io_en;
  logic [4:0] wa_idx, io_idx;
  logic [7:0] wa_val, io_val;
  logic [15:0] pr_val;
  cbbl_shift_t sh_kind;
  logic [7:0] sh_res, mem_rd;
  logic sh_c, sh_z, sh_n, sh_v;

  // Instruction fields stay put for the whole execution
  wire cbbl_op_t op = cbbl_op_t'(instr_q[OP_POS +: OP_W]);
  wire [4:0] rd_f = instr_q[RD_POS +: 5];
  wire [4:0] rr_f = instr_q[RR_POS +: 5];
  wire [7:0] imm_f = instr_q[IMM_POS +: 8];
  wire [2:0] bit_f = imm_f[2:0];
  wire [7:0] flag_mask = 8'h01 << bit_f;
  wire [7:0] rd_val = rf_q[rd_f];
  wire [7:0] rr_val = rf_q[rr_f];
  wire rr_bit = rr_val[bit_f];
  wire rd_msb = rd_val[7];
  wire rd_lsb = rd_val[0];
  wire [6:0] rd_hi7 = rd_val[7:1];
  // Pointer pairs sit at r27:r26, r29:r28 and r31:r30, and wrap to r1:r0 when rr_f[1:0] is 3
  wire [4:0] ptr_lo = PTR_X_LO + {2'b00, rr_f[1:0], 1'b0};
  wire [4:0] ptr_hi = ptr_lo + 5'h01;
  wire [15:0] ptr_val = {rf_q[ptr_hi], rf_q[ptr_lo]};
  wire [4:0] pair_d = {rd_f[4:1], 1'b0};
  wire [4:0] pair_s = {rr_f[4:1], 1'b0};
  wire [4:0] pair_d_hi = pair_d + 5'h01;
  wire [4:0] pair_s_hi = pair_s + 5'h01;
  wire [4:0] pr_idx = (op == op_copy_pair) ? pair_d : ptr_lo;
  wire [4:0] pr_idx_hi = pr_idx + 5'h01;
  wire [15:0] br_target = pc_rel(pc_q, imm_f[6:0]);
  wire first = (state_q == st_first);

  // Branch condition per flag test
  wire is_branch = (op == op_br_tclr) | (op == op_br_vset) |
                   (op == op_br_vclr) | (op == op_br_ion) |
                   (op == op_br_ioff);
  wire br_cond = ((op == op_br_tclr) & ~flags_q[SR_T]) |
                 ((op == op_br_vset) & flags_q[SR_V]) |
                 ((op == op_br_vclr) & ~flags_q[SR_V]) |
                 ((op == op_br_ion) & flags_q[SR_I]) |
                 ((op == op_br_ioff) & ~flags_q[SR_I]);

  // Bus decode; a write takes effect on the edge that sees ack high
  wire bus_req = wb_cyc_i & wb_stb_i;
  wire bus_wr = bus_req & wb_we_i & ack_q;
  wire lane0_wr = bus_wr & wb_sel_i[0];
  wire hit_instr = (wb_adr_i == ADR_INSTR);
  wire hit_pc = (wb_adr_i == ADR_PC);
  wire hit_flags = (wb_adr_i == ADR_FLAGS);
  wire hit_status = (wb_adr_i == ADR_STATUS);
  wire hit_sel = (wb_adr_i == ADR_SEL);
  wire hit_reg = (wb_adr_i == ADR_REGDATA);
  wire hit_mem = (wb_adr_i == ADR_MEMDATA);
  wire hit_io = (wb_adr_i == ADR_IODATA);
  wire launch = bus_wr & hit_instr & (state_q == st_idle);
  wire [31:0] instr_merge = wb_merge(instr_q, wb_dat_i, wb_sel_i);
  wire [31:0] pc_merge = wb_merge({16'h0000, pc_q}, wb_dat_i, wb_sel_i);
  wire [MEM_AW-1:0] mem_addr = (state_q == st_idle) ? sel_q :
                               addr_q[MEM_AW-1:0];

  // Shift kind from the opcode
  assign sh_kind = (op == op_shr) ? sh_right :
                   (op == op_rot_left) ? sh_rot_left :
                   (op == op_rot_right) ? sh_rot_right :
                   (op == op_sra) ? sh_arith : sh_left;

  cbbl_shift_unit u_shift (
    .kind(sh_kind),
    .val(rd_val),
    .cin(flags_q[SR_C]),
    .res(sh_res),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v)
  );

  // The executor never stores, so only the bus writes memory
  cbbl_data_mem u_mem (
    .mclk(mclk),
    .rd_addr(mem_addr),
    .rd_data(mem_rd),
    .wr_en(lane0_wr & hit_mem & (state_q == st_idle)),
    .wr_addr(sel_q),
    .wr_data(wb_dat_i[7:0])
  );

  // Read data for the bus; unmapped addresses read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_instr) rd_mux = instr_q;
    else if (hit_pc) rd_mux = {16'h0000, pc_q};
    else if (hit_flags) rd_mux = {24'h000000, flags_q};
    else if (hit_status) rd_mux = {28'h0000000, taken_q, cyc_q,
                                   state_q != st_idle};
    else if (hit_sel) rd_mux = {24'h000000, sel_q};
    else if (hit_reg) rd_mux = {24'h000000, rf_q[sel_q[4:0]]};
    else if (hit_mem) rd_mux = {24'h000000, mem_rd};
    else if (hit_io) rd_mux = {24'h000000, io_q[sel_q[4:0]]};
  end

  // Sequencer and datapath; bus writes only land while idle
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    flags_d = flags_q;
    cyc_d = cyc_q;
    taken_d = taken_q;
    addr_d = addr_q;
    wa_en = lane0_wr & hit_reg;
    wa_idx = sel_q[4:0];
    wa_val = wb_dat_i[7:0];
    pr_en = 1'b0;
    pr_val = ptr_val;
    io_en = lane0_wr & hit_io;
    io_idx = sel_q[4:0];
    io_val = wb_dat_i[7:0];
    case (state_q)
      st_idle: begin
        if (bus_wr & hit_pc) pc_d = pc_merge[15:0];
        if (lane0_wr & hit_flags) flags_d = wb_dat_i[7:0];
        if (launch) state_d = st_first;
      end
      st_first: begin
        io_en = 1'b0;
        wa_en = 1'b0;
        wa_idx = rd_f;
        pc_d = pc_q + 16'h0001;
        state_d = st_idle;
        cyc_d = 2'd1;
        taken_d = 1'b0;
        if (is_branch && br_cond) begin
          pc_d = br_target;
          taken_d = 1'b1;
          state_d = st_second;
        end
        case (op)
          op_io_set, op_io_clr: state_d = st_second;
          op_shl, op_shr, op_rot_left, op_rot_right, op_sra: begin
            wa_en = 1'b1;
            wa_val = sh_res;
            flags_d[SR_C] = sh_c;
            flags_d[SR_Z] = sh_z;
            flags_d[SR_N] = sh_n;
            flags_d[SR_V] = sh_v;
          end
          op_swap: begin
            wa_en = 1'b1;
            wa_val = {rd_val[3:0], rd_val[7:4]};
          end
          op_flag_set: flags_d = flags_q | flag_mask;
          op_flag_clr: flags_d = flags_q & ~flag_mask;
          op_bit_to_t: flags_d[SR_T] = rr_bit;
          op_t_to_bit: begin
            wa_en = 1'b1;
            wa_val = flags_q[SR_T] ? (rd_val | flag_mask) :
                                    (rd_val & ~flag_mask);
          end
          op_copy: begin
            wa_en = 1'b1;
            wa_val = rr_val;
          end
          op_copy_pair: begin
            pr_en = 1'b1;
            pr_val = {rf_q[pair_s_hi], rf_q[pair_s]};
          end
          op_imm: begin
            wa_en = 1'b1;
            wa_val = imm_f;
          end
          op_load, op_load_inc: begin
            addr_d = ptr_val;
            state_d = st_second;
          end
          op_load_dec: begin
            addr_d = ptr_val - 16'h0001;
            pr_en = 1'b1;
            pr_val = ptr_val - 16'h0001;
            state_d = st_second;
          end
          op_load_disp: begin
            addr_d = ptr_val + {10'h000, imm_f[5:0]};
            state_d = st_second;
          end
          default: ;
        endcase
      end
      st_second: begin
        io_en = 1'b0;
        wa_en = 1'b0;
        wa_idx = rd_f;
        wa_val = mem_rd;
        io_idx = rd_f;
        io_val = io_q[rd_f];
        state_d = st_idle;
        cyc_d = 2'd2;
        case (op)
          op_io_set: begin
            io_en = 1'b1;
            io_val = io_q[rd_f] | flag_mask;
          end
          op_io_clr: begin
            io_en = 1'b1;
            io_val = io_q[rd_f] & ~flag_mask;
          end
          op_load, op_load_dec, op_load_disp: wa_en = 1'b1;
          op_load_inc: begin
            wa_en = 1'b1;
            pr_en = 1'b1;
            pr_val = addr_q + 16'h0001;
          end
          default: ;
        endcase
      end
      default: state_d = st_idle;
    endcase
  end

  // Register file; a load into its own pointer lets the data win
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) rf_q[i] <= 8'h00;
    end else begin
      if (pr_en) begin
        rf_q[pr_idx] <= pr_val[7:0];
        rf_q[pr_idx_hi] <= pr_val[15:8];
      end
      if (wa_en) rf_q[wa_idx] <= wa_val;
    end
  end

  // I/O register space
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 32; i++) io_q[i] <= 8'h00;
    end else if (io_en) begin
      io_q[io_idx] <= io_val;
    end
  end

  // Control state
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= st_idle;
      pc_q <= PC_RST;
      flags_q <= FLAGS_RST;
      cyc_q <= 2'd0;
      taken_q <= 1'b0;
      addr_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      flags_q <= flags_d;
      cyc_q <= cyc_d;
      taken_q <= taken_d;
      addr_q <= addr_d;
    end
  end

  // Software-held words
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      instr_q <= INSTR_RST;
      sel_q <= SEL_RST;
    end else begin
      if (launch) instr_q <= instr_merge;
      if (lane0_wr & hit_sel) sel_q <= wb_dat_i[7:0];
    end
  end

  // Ack one cycle after the request, held off while executing so
  // that software cannot disturb an instruction in flight
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req & ~ack_q & (state_q == st_idle);
      dat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  transfer_branch_a: assert property (first &&
    op == op_br_tclr |=> pc_q == ($past(flags_q[SR_T]) ?
    $past(pc_q) + 16'h0001 : $past(br_target)))
    else $error("transfer branch target wrong");
  overflow_taken_a: assert property (first && op == op_br_vset &&
    flags_q[SR_V] |=> state_q == st_second && flags_q == $past(flags_q)
    ##1 state_q == st_idle) else $error("overflow branch not two cycles");
  overflow_clear_a: assert property (first && op == op_br_vclr |=>
    taken_q == !$past(flags_q[SR_V])) else $error("overflow clear sense");
  irq_branch_a: assert property (first && (op == op_br_ion ||
    op == op_br_ioff) |=> taken_q == ($past(flags_q[SR_I]) ==
    (op == op_br_ion))) else $error("interrupt branch sense wrong");
  io_bit_a: assert property (first && op == op_io_set |=> ##1
    io_q[rd_f][bit_f] && cyc_q == 2'd2) else $error("io bit not set");
  rotate_left_a: assert property (first && op == op_rot_left |=>
    rd_val == {$past(rd_hi7[5:0]), $past(rd_lsb), $past(flags_q[SR_C])}
    && flags_q[SR_C] == $past(rd_msb)) else $error("rotate left wrong");
  shift_right_a: assert property (first && op == op_shr |=>
    rd_val == {1'b0, $past(rd_hi7)} && flags_q[SR_C] == $past(rd_lsb)
    && !flags_q[SR_N]) else $error("logical right shift wrong");
  arith_shift_a: assert property (first && op == op_sra |=>
    rd_val == {$past(rd_msb), $past(rd_hi7)} && cyc_q == 2'd1)
    else $error("arithmetic shift wrong");
  flag_set_a: assert property (first && op == op_flag_set |=>
    flags_q == ($past(flags_q) | $past(flag_mask)) && state_q == st_idle)
    else $error("flag set touched other flags");
  flag_clear_a: assert property (first && op == op_flag_clr |=>
    flags_q == ($past(flags_q) & ~$past(flag_mask)))
    else $error("flag clear touched other flags");
  bit_to_t_a: assert property (first && op == op_bit_to_t |=>
    flags_q[SR_T] == $past(rr_bit) && flags_q[5:0] == $past(flags_q[5:0]))
    else $error("transfer flag not loaded");
  t_to_bit_a: assert property (first && op == op_t_to_bit |=>
    rd_val[bit_f] == $past(flags_q[SR_T]) && flags_q == $past(flags_q))
    else $error("register bit not loaded from transfer");
  irq_on_a: assert property (first && op == op_flag_set &&
    bit_f == 3'd7 |=> flags_q[SR_I] && flags_q[6:0] == $past(flags_q[6:0]))
    else $error("interrupt enable not set alone");
  copy_byte_a: assert property (first && op == op_copy |=>
    rd_val == $past(rr_val) && flags_q == $past(flags_q))
    else $error("register copy wrong");
  load_inc_a: assert property (first && op == op_load_inc &&
    rd_f < 5'd26 |=> ##1 ptr_val == $past(ptr_val, 2) + 16'h0001 &&
    rd_val == $past(mem_rd)) else $error("post-increment load wrong");
  load_dec_a: assert property (first && op == op_load_dec &&
    rd_f < 5'd26 |=> ptr_val == $past(ptr_val) - 16'h0001 &&
    addr_q == ptr_val) else $error("pre-decrement load wrong");
  load_disp_a: assert property (first && op == op_load_disp &&
    rd_f < 5'd26 |=> addr_q == $past(ptr_val) + {10'h000, imm_f[5:0]}
    ##1 $stable(ptr_val) && cyc_q == 2'd2)
    else $error("displacement load wrong");
  taken_flush_a: assert property (first && is_branch &&
    br_cond |=> state_q == st_second ##1 state_q == st_idle &&
    cyc_q == 2'd2) else $error("taken branch lacks flush cycle");

endmodule : cbbl_exec_core

//--- tb/cbbl_testbench.sv
/*
  Self-checking bench for the execution block: drives instruction words
  and register traffic over classic Wishbone and checks the results.
  Assumes MEMDATA writes land in data memory at the SEL address.
*/
`timescale 1ns/100ps
module testbench;
  import cbbl_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack;
  int fail_count = 0, comparisons = 0;

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  cbbl_exec_core i_dut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  task summarize;
    $display("errors %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // One classic cycle; the idle edge after it keeps drivers single-valued
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 40) begin
      fail_count++;
      summarize();
    end
    @(posedge mclk);
  endtask : wb

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check(q, e);
  endtask : rd

  task exe(input int o, input int d, input int r, input int m);
    wr(ADR_INSTR, {3'h0, o[4:0], 3'h0, d[4:0], 3'h0, r[4:0], m[7:0]});
  endtask : exe

  task ldi(input int r, input int v);
    exe(op_imm, r, r, v);
  endtask : ldi

  task reg_is(input int r, input int e);
    wr(ADR_SEL, {24'h0, r[7:0]});
    rd(ADR_REGDATA, {24'h0, e[7:0]});
  endtask : reg_is

  // Cycle count and taken flag of the last instruction, busy low
  task stat(input logic [1:0] c, input logic t);
    rd(ADR_STATUS, {28'h0, t, c, 1'b0});
  endtask : stat

  task t_reset;
    rd(ADR_PC, 32'h0);
    rd(ADR_FLAGS, 32'h0);
    rd(ADR_INSTR, 32'h0);
    rd(ADR_STATUS, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
  endtask : t_reset

  // Every branch with its flag both ways; the other flags inverted
  task automatic t_branch;
    int ops [5] = '{op_br_tclr, op_br_vset, op_br_vclr, op_br_ion,
                    op_br_ioff};
    int fb [5] = '{SR_T, SR_V, SR_V, SR_I, SR_I};
    logic want [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] s;
    logic [6:0] k;
    logic tk;
    for (int i = 0; i < 5; i++) begin
      for (int c = 0; c < 2; c++) begin
        s = c[0] ? (8'h01 << fb[i]) : ~(8'h01 << fb[i]);
        tk = (c[0] == want[i]);
        k = c[0] ? 7'h7E : 7'h05;
        wr(ADR_FLAGS, {24'h0, s});
        wr(ADR_PC, 32'h0040);
        exe(ops[i], 0, 0, {1'b0, k});
        rd(ADR_PC, tk ? 32'h41 + {{25{k[6]}}, k} : 32'h41);
        rd(ADR_FLAGS, {24'h0, s});
        stat(tk ? 2'd2 : 2'd1, tk);
      end
    end
  endtask : t_branch

  task t_io;
    wr(ADR_FLAGS, 32'hA5);
    wr(ADR_PC, 32'h0);
    wr(ADR_SEL, 32'h3);
    exe(op_io_set, 3, 3, 5);
    rd(ADR_IODATA, 32'h20);
    exe(op_io_set, 3, 3, 0);
    exe(op_io_clr, 3, 3, 5);
    rd(ADR_IODATA, 32'h01);
    rd(ADR_FLAGS, 32'hA5);
    rd(ADR_PC, 32'h3);
    stat(2'd2, 1'b0);
  endtask : t_io

  // All shift kinds on a plain value and on one that the logical and arithmetic right shifts take to zero
  task automatic t_shift;
    int ops [5] = '{op_shl, op_shr, op_rot_left, op_rot_right, op_sra};
    logic [7:0] v, r;
    logic c;
    for (int j = 0; j < 2; j++) begin
      v = j ? 8'h01 : 8'h96;
      for (int i = 0; i < 5; i++) begin
        case (i)
          0: {c, r} = {v, 1'b0};
          1: {r, c} = {1'b0, v};
          2: {c, r} = {v, 1'b1};
          3: {r, c} = {1'b1, v};
          default: {r, c} = {v[7], v};
        endcase
        ldi(4, v);
        wr(ADR_FLAGS, 32'hF1);
        exe(ops[i], 4, 4, 0);
        reg_is(4, r);
        rd(ADR_FLAGS, {28'hF, r[7] ^ c, r[7], r == 8'h00, c});
      end
    end
    stat(2'd1, 1'b0);
  endtask : t_shift

  task t_flags;
    for (int b = 0; b < 8; b++) begin
      wr(ADR_FLAGS, 32'h00);
      exe(op_flag_set, 0, 0, b);
      rd(ADR_FLAGS, {24'h0, 8'h01 << b});
      wr(ADR_FLAGS, 32'hFF);
      exe(op_flag_clr, 0, 0, b);
      rd(ADR_FLAGS, {24'h0, ~(8'h01 << b)});
    end
    stat(2'd1, 1'b0);
  endtask : t_flags

  task t_bits;
    wr(ADR_FLAGS, 32'h00);
    ldi(5, 8'h40);
    exe(op_bit_to_t, 5, 5, 6);
    rd(ADR_FLAGS, 32'h40);
    ldi(6, 8'h81);
    exe(op_t_to_bit, 6, 6, 3);
    reg_is(6, 8'h89);
    rd(ADR_FLAGS, 32'h40);
    exe(op_bit_to_t, 6, 6, 1);
    rd(ADR_FLAGS, 32'h00);
    stat(2'd1, 1'b0);
  endtask : t_bits

  task t_copy;
    ldi(7, 8'h3C);
    ldi(9, 8'hC3);
    wr(ADR_FLAGS, 32'h5A);
    exe(op_copy, 8, 7, 0);
    exe(op_copy_pair, 10, 8, 0);
    // Nibble swap is decoded too; it must leave the flags alone
    exe(op_swap, 7, 7, 0);
    reg_is(7, 8'hC3);
    reg_is(8, 8'h3C);
    reg_is(10, 8'h3C);
    reg_is(11, 8'hC3);
    rd(ADR_FLAGS, 32'h5A);
    stat(2'd1, 1'b0);
  endtask : t_copy

  // Pointer in r27:r26; distinct bytes show which address was read
  task automatic t_load;
    int a [3] = '{32'h20, 32'h21, 32'h25};
    int d [3] = '{32'h11, 32'h22, 32'h44};
    for (int i = 0; i < 3; i++) begin
      wr(ADR_SEL, a[i]);
      wr(ADR_MEMDATA, d[i]);
    end
    ldi(26, 8'h20);
    ldi(27, 8'h00);
    wr(ADR_FLAGS, 32'h3C);
    exe(op_load_inc, 1, 0, 0);
    reg_is(1, 8'h11);
    reg_is(26, 8'h21);
    stat(2'd2, 1'b0);
    exe(op_load_dec, 2, 0, 0);
    reg_is(2, 8'h11);
    reg_is(26, 8'h20);
    exe(op_load_disp, 3, 0, 5);
    reg_is(3, 8'h44);
    // Plain pointer load, with no pointer update
    exe(op_load, 4, 0, 0);
    reg_is(4, 8'h11);
    reg_is(26, 8'h20);
    rd(ADR_FLAGS, 32'h3C);
    stat(2'd2, 1'b0);
  endtask : t_load

  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_branch();
    t_io();
    t_shift();
    t_flags();
    t_bits();
    t_copy();
    t_load();
    summarize();
  end
endmodule : testbench
